/* File: logic/gpio_exp_consts.svh */
`ifndef GPIO_EXP_CONSTS_SVH
`define GPIO_EXP_CONSTS_SVH

// Command byte values that select a register
`define REG_INPUT 8'h00
`define REG_OUTPUT 8'h01
`define REG_DIR 8'h03
`define REG_LATCH 8'h42
`define REG_MASK 8'h45
`define REG_STATUS 8'h46
`define REG_STAGE 8'h4f

// Reset values
`define RST_OUTPUT 8'hff
`define RST_DIR 8'hff
`define RST_LATCH 8'h00
`define RST_MASK 8'hff
`define RST_STAGE 1'b0
`define RST_CMD 8'h00
`define RST_BYTE 8'h00

// Field positions and bit counts
`define STAGE_BIT 0
`define LAST_BIT 4'h7
`define RW_READ 1'b1

// Slave address base, upper four bits; arbitrary value
`define ADDR_BASE_DEFAULT 4'h5

`endif

/* File: logic/gpio_exp_pkg.sv */
package gpio_exp_pkg;
  // Serial slave sequencer states
  typedef enum logic [2:0] {
    st_idle, st_rx, st_rx_ack, st_tx, st_tx_ack, st_wait
  } bus_state_t;
  // What the byte being received means
  typedef enum logic [1:0] {k_addr, k_cmd, k_data} rx_kind_t;
endpackage

/* File: logic/i2c_gpio_expander_irq_core.sv */
// What this block does
// - One port-wide bit: 0 push-pull, 1 open-drain with high side off.
// - Input pins have both drivers off, pin is high impedance.
// - Output pins drive high or low from the output value bit.
// - Reset initialises every register and the serial sequencer to defaults.
// - Any edge on an input pin raises an interrupt condition.
// - Non-latched condition clears when pin returns or the port is read.
// - Read clear happens at the ACK/NACK bit after the rising clock.
// - A change during that ACK/NACK pulse may be lost or be short.
// - After clearing, every later change is detected again.
// - Output pins never cause an interrupt.
// - Turning an output into a mismatching input may raise an interrupt.
// - Interrupt pin is active low and only pulls low or releases.
// - Latched condition clears only on a read, not on pin return.
// - Write: address with bit 0, command byte, then data bytes.
// - Any number of data bytes accepted in one write.
// - Read: address+0, command, repeated start, address+1, then data.
// - Port data is captured for return at the ACK clock rising edge.
// - Stop may end a transfer anytime; last acknowledged data stays valid.
// - Last command byte is kept for reads started without one.
// - Direction bit 1 makes an input, 0 an output; resets to 1.
// - Mask bit 1 keeps that pin from asserting interrupt; resets to 1.
// - Latched pin change loads its value into input register until read.
// - Status register shows causing pins, zero where masked.
`include "gpio_exp_consts.svh"

module i2c_gpio_expander_irq_core #(
  parameter logic [3:0] ADDR_BASE = `ADDR_BASE_DEFAULT,
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Address straps
  input wire logic [2:0] addr_pin,
  // Port pins
  input wire logic [WIDTH-1:0] gpio_in,
  output logic [WIDTH-1:0] gpio_out,
  output logic [WIDTH-1:0] gpio_oe_n,
  // Interrupt, open drain
  output logic int_out,
  output logic int_oe_n
);

  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic [2:0] addr_s1, addr_s2;
  logic [WIDTH-1:0] pin_s1, pin_s;
  logic scl_rise, scl_fall, start_det, stop_det;
  gpio_exp_pkg::bus_state_t state;
  gpio_exp_pkg::rx_kind_t kind;
  logic [3:0] cnt;
  logic [7:0] shift, tx, cmd_reg, rx_byte, rd_val;
  logic rw, ack_on, sda_low, byte_end, addr_hit, wr_fire, rd_clr;
  logic [WIDTH-1:0] out_val, dir, latch_en, mask;
  logic stage;
  logic [WIDTH-1:0] snap, lat_pend, lat_val, pin_chg, lat_set, src, status, in_view;

  // Two flops on every bus, strap and port pin input (not srst) before any logic looks at it
  always_ff @(posedge core_clk) begin
    scl_s1 <= scl_in;
    scl_s2 <= scl_s1;
    scl_d <= scl_s2;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    sda_d <= sda_s2;
    addr_s1 <= addr_pin;
    addr_s2 <= addr_s1;
    pin_s1 <= gpio_in;
    pin_s <= pin_s1;
  end

  // Bus events seen on the sampled lines
  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign rx_byte = {shift[6:0], sda_s2};
  assign byte_end = scl_rise && state == gpio_exp_pkg::st_rx && cnt == `LAST_BIT;
  assign addr_hit = rx_byte[7:1] == {ADDR_BASE, addr_s2};
  assign wr_fire = byte_end && kind == gpio_exp_pkg::k_data;
  // Master ACK/NACK rise of a byte taken from the input register
  assign rd_clr = scl_rise && state == gpio_exp_pkg::st_tx_ack && ack_on
    && cmd_reg == `REG_INPUT;

  // Serial slave sequencer; only stop returns to idle, start restarts anywhere
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= gpio_exp_pkg::st_idle;
      kind <= gpio_exp_pkg::k_addr;
      cnt <= 4'h0;
      shift <= `RST_BYTE;
      tx <= `RST_BYTE;
      rw <= 1'b0;
      ack_on <= 1'b0;
      sda_low <= 1'b0;
    end else if (start_det) begin
      state <= gpio_exp_pkg::st_rx;
      kind <= gpio_exp_pkg::k_addr;
      cnt <= 4'h0;
      sda_low <= 1'b0;
    end else if (stop_det) begin
      state <= gpio_exp_pkg::st_idle;
      sda_low <= 1'b0;
    end else begin
      case (state)
        gpio_exp_pkg::st_rx: begin
          if (scl_rise) begin
            shift <= rx_byte;
            cnt <= cnt + 4'h1;
            if (cnt == `LAST_BIT) begin
              ack_on <= 1'b0;
              if (kind == gpio_exp_pkg::k_addr) begin
                rw <= rx_byte[0];
                state <= addr_hit ? gpio_exp_pkg::st_rx_ack : gpio_exp_pkg::st_wait;
              end else begin
                state <= gpio_exp_pkg::st_rx_ack;
              end
            end
          end
        end
        gpio_exp_pkg::st_rx_ack: begin
          if (scl_fall && !ack_on) begin
            sda_low <= 1'b1;
            ack_on <= 1'b1;
          end else if (scl_rise && ack_on && rw == `RW_READ && kind == gpio_exp_pkg::k_addr) begin
            tx <= rd_val;
          end else if (scl_fall && ack_on) begin
            cnt <= 4'h0;
            if (rw == `RW_READ && kind == gpio_exp_pkg::k_addr) begin
              sda_low <= ~tx[7];
              tx <= {tx[6:0], 1'b0};
              state <= gpio_exp_pkg::st_tx;
            end else begin
              sda_low <= 1'b0;
              kind <= kind == gpio_exp_pkg::k_addr ? gpio_exp_pkg::k_cmd : gpio_exp_pkg::k_data;
              state <= gpio_exp_pkg::st_rx;
            end
          end
        end
        gpio_exp_pkg::st_tx: begin
          if (scl_fall) begin
            sda_low <= ~tx[7]; // Open drain: a one is a release
            tx <= {tx[6:0], 1'b0};
          end else if (scl_rise) begin
            cnt <= cnt + 4'h1;
            if (cnt == `LAST_BIT) begin
              ack_on <= 1'b0;
              state <= gpio_exp_pkg::st_tx_ack;
            end
          end
        end
        gpio_exp_pkg::st_tx_ack: begin
          if (scl_fall && !ack_on) begin
            sda_low <= 1'b0;
            ack_on <= 1'b1;
          end else if (scl_rise && ack_on) begin
            cnt <= 4'h0;
            if (!sda_s2) begin
              tx <= rd_val;
              state <= gpio_exp_pkg::st_tx;
            end else begin
              state <= gpio_exp_pkg::st_wait;
            end
          end
        end
        gpio_exp_pkg::st_idle, gpio_exp_pkg::st_wait: begin
          sda_low <= 1'b0;
        end
        default: begin
          state <= gpio_exp_pkg::st_idle;
          sda_low <= 1'b0;
        end
      endcase
    end
  end

  // Command byte survives stops so a bare read reuses it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_reg <= `RST_CMD;
    end else if (byte_end && kind == gpio_exp_pkg::k_cmd) begin
      cmd_reg <= rx_byte;
    end
  end

  // Writable registers; unknown commands are acked and ignored
  always_ff @(posedge core_clk) begin
    if (srst) begin
      out_val <= `RST_OUTPUT;
      dir <= `RST_DIR;
      latch_en <= `RST_LATCH;
      mask <= `RST_MASK;
      stage <= `RST_STAGE;
    end else if (wr_fire) begin
      case (cmd_reg)
        `REG_OUTPUT: out_val <= rx_byte[WIDTH-1:0];
        `REG_DIR: dir <= rx_byte[WIDTH-1:0];
        `REG_LATCH: latch_en <= rx_byte[WIDTH-1:0];
        `REG_MASK: mask <= rx_byte[WIDTH-1:0];
        `REG_STAGE: stage <= rx_byte[`STAGE_BIT];
        default: stage <= stage;
      endcase
    end
  end

  // Change detection: an input pin differs from the value last read
  assign pin_chg = dir & (pin_s ^ snap);
  assign lat_set = pin_chg & latch_en & ~lat_pend;
  assign src = ((pin_chg & ~latch_en) | lat_pend) & dir;
  assign status = src & ~mask;
  assign in_view = (lat_pend & lat_val) | (~lat_pend & pin_s);

  // Latched events hold until the port is read; a read resyncs the reference
  always_ff @(posedge core_clk) begin
    if (srst) begin
      snap <= '0;
      lat_pend <= '0;
      lat_val <= '0;
    end else begin
      if (rd_clr) begin
        snap <= pin_s;
      end
      // A pin returning to its old level leaves a latched event pending
      lat_pend <= (rd_clr ? '0 : lat_pend) | (rd_clr ? '0 : lat_set);
      lat_val <= (lat_val & ~lat_set) | (pin_s & lat_set);
    end
  end

  // Register read multiplexer, reserved bits read as zero
  always_comb begin
    rd_val = `RST_BYTE;
    case (cmd_reg)
      `REG_INPUT: rd_val[WIDTH-1:0] = in_view;
      `REG_OUTPUT: rd_val[WIDTH-1:0] = out_val;
      `REG_DIR: rd_val[WIDTH-1:0] = dir;
      `REG_LATCH: rd_val[WIDTH-1:0] = latch_en;
      `REG_MASK: rd_val[WIDTH-1:0] = mask;
      `REG_STATUS: rd_val[WIDTH-1:0] = status;
      `REG_STAGE: rd_val[`STAGE_BIT] = stage;
      default: rd_val = `RST_BYTE;
    endcase
  end

  // Pin drivers: high side only in push-pull, nothing on inputs
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_pin
      assign gpio_out[gi] = out_val[gi];
      assign gpio_oe_n[gi] = dir[gi] | (stage & out_val[gi]);
    end
  endgenerate

  // Open-drain outputs only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe_n = ~sda_low;
  assign int_out = 1'b0;
  assign int_oe_n = ~|status;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_input_hiz: assert property ((dir & ~gpio_oe_n) == '0)
    else $error("input pin is driven");
  a_od_no_high: assert property (stage |-> (~gpio_oe_n & gpio_out) == '0)
    else $error("open-drain pin drives high");
  a_pp_drives: assert property (!stage |-> (~dir & gpio_oe_n) == '0)
    else $error("push-pull output not driven");
  a_reset_defaults: assert property (disable iff (1'b0) srst |=> dir == `RST_DIR
    && mask == `RST_MASK && stage == `RST_STAGE && state == gpio_exp_pkg::st_idle)
    else $error("reset defaults wrong");
  a_output_no_irq: assert property ((status & ~dir) == '0 && (status & mask) == '0)
    else $error("output or masked pin in status");
  a_int_never_high: assert property (int_out == 1'b0 && (int_oe_n == (status == '0)))
    else $error("interrupt pin drives high or disagrees");
  a_latch_edge_irq: assert property (
    ((pin_s ^ $past(pin_s)) & dir & latch_en & ~mask) != '0
    && !rd_clr && $stable(dir) && $stable(mask) |=> !int_oe_n)
    else $error("latched edge missed");
  a_latch_holds: assert property (
    lat_pend != '0 && !rd_clr |=> (lat_pend & $past(lat_pend)) == $past(lat_pend))
    else $error("latched event lost without read");
  a_read_resync: assert property (rd_clr |=> snap == $past(pin_s) && lat_pend == '0)
    else $error("read did not clear");
  a_cmd_kept: assert property (stop_det |=> $stable(cmd_reg))
    else $error("command byte lost on stop");

  // A matching address byte is answered with an acknowledge
  a_addr_ack: assert property (
    byte_end && kind == gpio_exp_pkg::k_addr && addr_hit |=> state == gpio_exp_pkg::st_rx_ack)
    else $error("own address not answered");
  // Any other address leaves the bus alone until the next start or stop
  a_addr_miss: assert property (
    byte_end && kind == gpio_exp_pkg::k_addr && !addr_hit |=> state == gpio_exp_pkg::st_wait)
    else $error("foreign address not ignored");
  // The acknowledge is pulled low one cycle after the clock falls
  a_ack_driven: assert property (
    scl_fall && state == gpio_exp_pkg::st_rx_ack && !ack_on |=> !sda_oe_n)
    else $error("acknowledge not driven");
  // The command byte is kept once all eight bits are in
  a_cmd_capture: assert property (
    byte_end && kind == gpio_exp_pkg::k_cmd |=> cmd_reg == $past(rx_byte))
    else $error("command byte not captured");
  // Every data byte to the output register lands there, no pointer step
  a_out_write: assert property (
    wr_fire && cmd_reg == `REG_OUTPUT |=> out_val == $past(rx_byte[WIDTH-1:0]))
    else $error("output write lost");
  // Direction writes land in full; a later stop does not undo them
  a_dir_write: assert property (
    wr_fire && cmd_reg == `REG_DIR |=> dir == $past(rx_byte[WIDTH-1:0]))
    else $error("direction write lost");
  // A master acknowledge reloads the selected register for the next byte
  a_tx_reload: assert property (
    scl_rise && state == gpio_exp_pkg::st_tx_ack && ack_on && !sda_s2 |=> tx == $past(rd_val))
    else $error("read byte not resampled");
  // A not-acknowledge ends the data phase until start or stop
  a_nack_ends: assert property (
    scl_rise && state == gpio_exp_pkg::st_tx_ack && ack_on && sda_s2
      |=> state == gpio_exp_pkg::st_wait)
    else $error("not-acknowledge ignored");
  // A start or repeated start restarts address reception from any state
  a_start_restart: assert property (
    start_det |=> state == gpio_exp_pkg::st_rx && kind == gpio_exp_pkg::k_addr && cnt == 4'h0)
    else $error("start not honoured");
  // A stop returns to idle with the data line released
  a_stop_idle: assert property (
    stop_det |=> state == gpio_exp_pkg::st_idle && sda_oe_n)
    else $error("stop not honoured");
  // Bit counter stays inside a byte while bits are shifted
  a_bit_range: assert property (
    state == gpio_exp_pkg::st_rx || state == gpio_exp_pkg::st_tx |-> cnt <= `LAST_BIT)
    else $error("bit counter out of range");
  // Idle and ignoring states never hold the data line low
  a_wait_quiet: assert property (
    state == gpio_exp_pkg::st_wait || state == gpio_exp_pkg::st_idle |-> sda_oe_n)
    else $error("data line held while ignoring");
  // After a read clear with the pins still, the interrupt is released
  a_clear_release: assert property (
    rd_clr ##1 pin_s == $past(pin_s) |-> int_oe_n)
    else $error("read did not release interrupt");

endmodule // i2c_gpio_expander_irq_core

/* File: sim/i2c_master_model.sv */
module i2c_master_model #(
  parameter logic [6:0] ADDR = 7'h00
) (
  // Clock
  input wire logic core_clk,
  // Bus lines
  input wire logic sda_line,
  output logic scl,
  output logic sda_rel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx;
  logic ack;
  // Idle bus: both lines released, clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // Waits, then sets both lines; every change lands on a falling core edge
  task automatic step(input int w, input logic s, input logic c);
    repeat (w) @(negedge core_clk);
    sda_rel = s;
    scl = c;
  endtask
  // Start or repeated start, issued only from idle or after a whole byte
  task automatic start();
    step(4, 1'b1, 1'b0);
    step(1, 1'b1, 1'b1);
    step(4, 1'b0, 1'b1);
    step(4, 1'b0, 1'b0);
  endtask
  // Data falls 4 clocks after the fall, then rises 4 clocks into the clock high time
  task automatic stop();
    step(4, 1'b0, 1'b0);
    step(1, 1'b0, 1'b1);
    step(4, 1'b1, 1'b1);
    repeat (8) @(negedge core_clk);
  endtask
  // One bit slot of 800 ns: 5 clocks low, 3 high
  task automatic bitio(input logic b, output logic s);
    step(4, b, 1'b0);
    step(1, b, 1'b1);
    repeat (2) @(negedge core_clk);
    s = sda_line;
    step(1, b, 1'b0);
  endtask
  // One byte MSB first, then the ninth bit
  task automatic xfer(input logic [7:0] t, input logic ai, output logic [7:0] r,
                      output logic ao);
    for (int i = 7; i >= 0; i--) bitio(t[i], r[i]);
    bitio(ai, ao);
  endtask
  // Address with write bit, command, then n data bytes
  task automatic wr(input logic [7:0] c, input logic [7:0] d0, input logic [7:0] d1,
                    input int n);
    start();
    xfer({ADDR, 1'b0}, 1'b1, rx, ack);
    xfer(c, 1'b1, rx, ack);
    for (int k = 0; k < n; k++) xfer((k != 0) ? d1 : d0, 1'b1, rx, ack);
    stop();
  endtask
  // Optional command phase, repeated start, read; last byte not acked
  task automatic rd(input logic uc, input logic [7:0] c, input int n, output logic [7:0] d);
    start();
    if (uc) begin
      xfer({ADDR, 1'b0}, 1'b1, rx, ack);
      xfer(c, 1'b1, rx, ack);
      start();
    end
    xfer({ADDR, 1'b1}, 1'b1, rx, ack);
    for (int k = 0; k < n; k++) xfer(8'hff, k == n - 1, d, ack);
    stop();
  endtask
endmodule // i2c_master_model

/* File: sim/i2c_gpio_expander_irq_core_tb.sv */
`include "gpio_exp_consts.svh"

module i2c_gpio_expander_irq_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] addr_pin = 3'h2;
  logic [7:0] gpio_in = 8'h00;
  logic [7:0] gpio_out, gpio_oe_n, d;
  logic sda_out, sda_oe_n, int_out, int_oe_n, scl, sda_rel, ack;
  wire sda_line;
  int num_errors = 0;
  int num_checks = 0;
  logic [7:0] regs [5] = '{`REG_OUTPUT, `REG_DIR, `REG_LATCH, `REG_MASK, `REG_STAGE};
  logic [7:0] rstv [5] = '{`RST_OUTPUT, `RST_DIR, `RST_LATCH, `RST_MASK, {7'h00, `RST_STAGE}};
  // Open-drain data line with pull-up
  assign sda_line = sda_rel & (sda_oe_n | sda_out);
  always #50 core_clk = ~core_clk;
  i2c_gpio_expander_irq_core i_dut (
    .core_clk(core_clk), .srst(srst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_pin(addr_pin), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .int_out(int_out), .int_oe_n(int_oe_n));
  i2c_master_model #(.ADDR({`ADDR_BASE_DEFAULT, 3'h2})) i_host (
    .core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bounded wait for the interrupt level; running out ends the run
  task automatic wait_int(input logic e);
    for (int k = 0; k < 40 && int_oe_n !== e; k++) @(negedge core_clk);
    chk("int_oe_n", {7'h00, int_oe_n}, {7'h00, e});
    if (int_oe_n !== e) final_report();
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge core_clk);
    srst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("gpio_oe_n", gpio_oe_n, 8'hff);
    chk("int_out", {7'h00, int_out}, 8'h00);
    for (int k = 0; k < 5; k++) begin
      i_host.rd(1'b1, regs[k], 1, d);
      chk("reset value", d, rstv[k]);
    end
    // A foreign address must go unanswered
    i_host.start();
    i_host.xfer({`ADDR_BASE_DEFAULT, 3'h3, 1'b0}, 1'b1, d, ack);
    i_host.stop();
    chk("foreign ack", {7'h00, ack}, 8'h01);
    // The own address alone is answered, then a stop ends the frame
    i_host.start();
    i_host.xfer({`ADDR_BASE_DEFAULT, 3'h2, 1'b0}, 1'b1, d, ack);
    i_host.stop();
    chk("own ack", {7'h00, ack}, 8'h00);
    // Stage chosen before pins turn into outputs
    i_host.wr(`REG_STAGE, 8'h01, 8'h00, 1);
    i_host.wr(`REG_OUTPUT, 8'h55, 8'h0f, 2);
    chk("gpio_out", gpio_out, 8'h0f);
    i_host.wr(`REG_DIR, 8'h00, 8'h00, 1);
    chk("gpio_oe_n", gpio_oe_n, 8'h0f);
    i_host.wr(`REG_STAGE, 8'h00, 8'h00, 1);
    chk("gpio_oe_n", gpio_oe_n, 8'h00);
    i_host.wr(`REG_MASK, 8'h00, 8'h00, 1);
    gpio_in = 8'h02;
    repeat (10) @(negedge core_clk);
    chk("int_oe_n", {7'h00, int_oe_n}, 8'h01);
    i_host.wr(`REG_DIR, 8'hff, 8'hff, 1);
    wait_int(1'b0);
    i_host.rd(1'b1, `REG_INPUT, 2, d);
    chk("input", d, 8'h02);
    wait_int(1'b1);
    // Non-latched edges, return, re-detection and masking
    gpio_in = 8'h03;
    wait_int(1'b0);
    gpio_in = 8'h02;
    wait_int(1'b1);
    gpio_in = 8'h03;
    wait_int(1'b0);
    i_host.rd(1'b1, `REG_STATUS, 1, d);
    chk("status", d, 8'h01);
    i_host.wr(`REG_MASK, 8'h01, 8'h01, 1);
    wait_int(1'b1);
    i_host.rd(1'b1, `REG_STATUS, 1, d);
    chk("status", d, 8'h00);
    i_host.wr(`REG_MASK, 8'h00, 8'h00, 1);
    wait_int(1'b0);
    i_host.rd(1'b1, `REG_INPUT, 1, d);
    chk("input", d, 8'h03);
    wait_int(1'b1);
    // Latched bit 0 holds the level of its change until read
    i_host.wr(`REG_LATCH, 8'h01, 8'h01, 1);
    gpio_in = 8'h02;
    wait_int(1'b0);
    gpio_in = 8'h03;
    repeat (10) @(negedge core_clk);
    chk("int_oe_n", {7'h00, int_oe_n}, 8'h00);
    i_host.rd(1'b1, `REG_INPUT, 1, d);
    chk("latched", d, 8'h02);
    wait_int(1'b1);
    i_host.rd(1'b0, 8'h00, 1, d);
    chk("input", d, 8'h03);
    i_host.rd(1'b1, `REG_LATCH, 1, d);
    chk("latch", d, 8'h01);
    // Mid-run reset brings registers, command byte and sequencer back
    srst = 1'b1;
    repeat (3) @(negedge core_clk);
    srst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("gpio_oe_n", gpio_oe_n, `RST_DIR);
    chk("gpio_out", gpio_out, `RST_OUTPUT);
    chk("int_oe_n", {7'h00, int_oe_n}, 8'h01);
    i_host.rd(1'b0, 8'h00, 1, d);
    chk("input", d, 8'h03);
    i_host.rd(1'b1, `REG_LATCH, 1, d);
    chk("latch", d, `RST_LATCH);
    final_report();
  end
endmodule // i2c_gpio_expander_irq_core_tb
